// ==== shared/ppc_pkg.sv ====
// shared constants and types for the parallel peripheral port controller
package ppc_pkg;
    localparam int CLK_HZ = 10_000_000;
    // strobe width and reader settle time, in ns
    localparam int HOLD_NS = 1000;
    localparam int HOLD_CYC = (HOLD_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
    localparam logic [3:0] HOLD_LOAD = 4'(HOLD_CYC - 1);

    // control port bit positions
    localparam int CTL_ENA_N = 4;
    localparam int CTL_RP_DIR = 5;
    localparam int CTL_PG_DIR = 6;
    localparam int CTL_IRQ = 7;
    localparam logic [7:0] CTRL_RESET = 8'h7F;
    localparam logic [7:0] DATA_IDLE = 8'hFF;

    // select codes
    localparam logic [3:0] SEL_PG_RD_DATA = 4'h3;
    localparam logic [3:0] SEL_PG_RD_STAT = 4'h4;
    localparam logic [3:0] SEL_STATUS = 4'hC;

    // host flag byte positions
    localparam int FLG_OBF = 0;
    localparam int FLG_IBF = 1;
    localparam int FLG_BUSY = 2;
    localparam int FLG_CD = 3;

    // combined status byte positions, all active low
    localparam int ST_PUNCH_RDY = 0;
    localparam int ST_PUNCH_PWR = 1;
    localparam int ST_READER_RDY = 2;
    localparam int ST_READER_PWR = 3;
    localparam int ST_PRN_BUSY = 4;
    localparam int ST_PRN_ONLINE = 6;
    // printer ack and programmer ack bits are never trusted
    localparam logic [7:0] STATUS_VALID_MASK = 8'h5F;
    localparam logic [7:0] STATUS_RESET = 8'hFF;

    // command byte layout: [7] irq write, [5:4] operation, [3:0] select code
    localparam int CMD_IRQ = 7;
    localparam logic [1:0] OP_OUT = 2'h0;
    localparam logic [1:0] OP_STROBE_IN = 2'h1;
    localparam logic [1:0] OP_READER = 2'h2;
    localparam logic [1:0] OP_DETAIL = 2'h3;

    typedef struct packed {
        logic status_enable_n;
        logic printer_control_b_n;
        logic printer_control_a_n;
        logic printer_byte_strobe_n;
        logic reader_advance_right_n;
        logic reader_advance_left_n;
        logic punch_strobe_n;
        logic programmer_reset_n;
        logic programmer_status_read_req_n;
        logic programmer_data_read_req_n;
        logic programmer_write_strobe_1_n;
        logic programmer_write_strobe_2_n;
        logic programmer_write_strobe_0_n;
    } strobe_type;

    typedef struct packed {
        logic command_data_flag;
        logic controller_busy_flag;
        logic in_buffer_full_flag;
        logic out_buffer_full_flag;
    } host_flags_type;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_PLACE = 3'b001,
        ST_SETUP = 3'b011,
        ST_ENABLE = 3'b010,
        ST_HOLD = 3'b110,
        ST_DISABLE = 3'b111,
        ST_RESTORE = 3'b101,
        ST_REPLY = 3'b100
    } seq_state_type;
endpackage : ppc_pkg

// ==== hdl/strobe_decoder.sv ====
// one-of-thirteen active-low strobe decoder with registered outputs
`timescale 1ns/10ps
module strobe_decoder (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // control port fields
    input wire logic [3:0] code,
    input wire logic enable_n,
    // decoded strobes
    output ppc_pkg::strobe_type strobes
);
    function automatic logic [12:0] decode(input logic [3:0] c, input logic en_n);
        logic [12:0] d;
        d = 13'h1FFF;
        if (!en_n && c < 4'hD) begin
            d[c] = 1'b0;
        end
        return d;
    endfunction : decode

    always_ff @(posedge clk) begin
        if (rst) begin
            strobes <= '1;
        end else begin
            strobes <= ppc_pkg::strobe_type'(decode(code, enable_n));
        end
    end
endmodule : strobe_decoder

// ==== hdl/host_buffer.sv ====
// host byte buffer with input, output and four handshake flags
`timescale 1ns/10ps
module host_buffer (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // host strobes, already synchronised
    input wire logic sel_n,
    input wire logic rd_n,
    input wire logic wr_n,
    input wire logic addr_lsb,
    input wire logic [7:0] data_in,
    // host data drivers
    output logic [7:0] host_data_out,
    output logic host_data_oe_n,
    // controller side
    input wire logic take,
    input wire logic place,
    input wire logic [7:0] place_byte,
    input wire logic place_is_status,
    input wire logic busy,
    output logic [7:0] in_byte,
    output ppc_pkg::host_flags_type flags
);
    logic rd_act_reg;
    logic wr_act_reg;
    logic [7:0] out_byte_reg;
    logic rd_act;
    logic wr_act;
    logic wr_done;
    logic rd_start;
    logic [7:0] flag_byte;

    assign rd_act = !sel_n && !rd_n;
    assign wr_act = !sel_n && !wr_n;
    assign wr_done = wr_act_reg && !wr_act;
    assign rd_start = rd_act && !rd_act_reg;
    always_comb begin
        flag_byte = 8'h00;
        flag_byte[ppc_pkg::FLG_OBF] = flags.out_buffer_full_flag;
        flag_byte[ppc_pkg::FLG_IBF] = flags.in_buffer_full_flag;
        flag_byte[ppc_pkg::FLG_BUSY] = flags.controller_busy_flag;
        flag_byte[ppc_pkg::FLG_CD] = flags.command_data_flag;
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            rd_act_reg <= 1'b0;
            wr_act_reg <= 1'b0;
        end else begin
            rd_act_reg <= rd_act;
            wr_act_reg <= wr_act;
        end
    end

    // drivers turn only on the read strobe; the controller never starts a cycle
    always_ff @(posedge clk) begin
        if (rst) begin
            host_data_oe_n <= 1'b1;
        end else begin
            host_data_oe_n <= !rd_act;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            host_data_out <= 8'h00;
        end else if (rd_start) begin
            host_data_out <= addr_lsb ? flag_byte : out_byte_reg;
        end
    end

    // trailing edge of the write captures, so the data has long settled
    always_ff @(posedge clk) begin
        if (rst) begin
            in_byte <= 8'h00;
            flags.command_data_flag <= 1'b0;
        end else if (wr_done) begin
            in_byte <= data_in;
            flags.command_data_flag <= addr_lsb;
        end else if (place) begin
            flags.command_data_flag <= place_is_status;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            flags.in_buffer_full_flag <= 1'b0;
        end else if (wr_done) begin
            flags.in_buffer_full_flag <= 1'b1;
        end else if (take) begin
            flags.in_buffer_full_flag <= 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            out_byte_reg <= 8'h00;
            flags.out_buffer_full_flag <= 1'b0;
        end else if (place) begin
            out_byte_reg <= place_byte;
            flags.out_buffer_full_flag <= 1'b1;
        end else if (rd_start && !addr_lsb) begin
            flags.out_buffer_full_flag <= 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            flags.controller_busy_flag <= 1'b0;
        end else begin
            flags.controller_busy_flag <= busy;
        end
    end
endmodule : host_buffer

// ==== hdl/parallel_peripheral_port_controller.sv ====
// controller between host byte buffer and paper tape, printer and programmer
`timescale 1ns/10ps
// How it works
// - host starts every transfer; controller only answers
// - buffer holds byte plus four flags
// - address lsb marks command or data
// - buffer acts only while port selected
// - host drivers follow the read strobe only
// - flags show byte taken or byte placed
// - interrupt comes from control port top bit
// - init low resets and aborts peripheral work
// - low nibble selects strobe when enable low
// - two bits steer reader/punch and programmer drivers
// - strobe made by two control writes
// - idle: data ones, all drivers outward
// - output: place byte, set code, enable, disable
// - codes 0-5 drive programmer strobes
// - codes 6-8: punch, left, right advance
// - codes 9-12 printer and status; 13-15 none
// - programmer read: dir low, enable, sample, end
// - reader read: one write, dir low, sample
// - status enable turns printer pair inward
// - ack bits invalid; ack pulse sensed separately
// - detailed status derived from combined status
module parallel_peripheral_port_controller (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    input wire logic system_init_n,
    // host port
    input wire logic port_select_n,
    input wire logic host_rd_n,
    input wire logic host_wr_n,
    input wire logic host_addr_lsb,
    input wire logic [7:0] host_data_in,
    output logic [7:0] host_data_out,
    output logic host_data_oe_n,
    output logic host_irq,
    // peripheral data port
    input wire logic [7:0] periph_data_in,
    output logic [7:0] periph_data_out,
    output logic periph_data_oe_n,
    // driver pair directions, high means outward
    output logic reader_punch_dir,
    output logic programmer_dir,
    output logic printer_dir,
    // decoded strobes and acknowledge sense
    output ppc_pkg::strobe_type strobes,
    input wire logic pulse_sense_input
);
    // pin synchronisers
    logic [11:0] host_s1_reg;
    logic [11:0] host_s2_reg;
    logic [7:0] pdata_s1_reg;
    logic [7:0] pdata_s2_reg;
    logic init_s1_reg;
    logic init_s2_reg;
    logic ack_s1_reg;
    logic ack_s2_reg;
    logic ack_s3_reg;
    logic srst;

    always_ff @(posedge clk) begin
        if (rst) begin
            host_s1_reg <= 12'hE00;
            host_s2_reg <= 12'hE00;
            init_s1_reg <= 1'b1;
            init_s2_reg <= 1'b1;
            ack_s1_reg <= 1'b1;
            ack_s2_reg <= 1'b1;
            ack_s3_reg <= 1'b1;
            pdata_s1_reg <= 8'hFF;
            pdata_s2_reg <= 8'hFF;
        end else begin
            host_s1_reg <= {port_select_n, host_rd_n, host_wr_n, host_addr_lsb, host_data_in};
            host_s2_reg <= host_s1_reg;
            init_s1_reg <= system_init_n;
            init_s2_reg <= init_s1_reg;
            ack_s1_reg <= pulse_sense_input;
            ack_s2_reg <= ack_s1_reg;
            ack_s3_reg <= ack_s2_reg;
            pdata_s1_reg <= periph_data_in;
            pdata_s2_reg <= pdata_s1_reg;
        end
    end

    // init aborts whatever sequence runs and returns the port to idle
    assign srst = rst || !init_s2_reg;

    ppc_pkg::host_flags_type flags;
    logic [7:0] in_byte;
    logic take;
    logic place;
    logic [7:0] place_byte;
    logic place_is_status;
    logic busy;

    host_buffer buffer (
        .clk(clk),
        .rst(srst),
        .sel_n(host_s2_reg[11]),
        .rd_n(host_s2_reg[10]),
        .wr_n(host_s2_reg[9]),
        .addr_lsb(host_s2_reg[8]),
        .data_in(host_s2_reg[7:0]),
        .host_data_out(host_data_out),
        .host_data_oe_n(host_data_oe_n),
        .take(take),
        .place(place),
        .place_byte(place_byte),
        .place_is_status(place_is_status),
        .busy(busy),
        .in_byte(in_byte),
        .flags(flags)
    );

    // sequencer
    ppc_pkg::seq_state_type state_reg;
    logic [7:0] ctrl_reg;
    logic [7:0] out_data_reg;
    logic [7:0] sample_reg;
    logic [7:0] status_reg;
    logic [3:0] hold_reg;
    logic [1:0] op_reg;
    logic ack_seen_reg;
    logic [7:0] detail;
    logic is_cmd;
    logic ack_edge;
    logic ack_clear;

    assign is_cmd = flags.in_buffer_full_flag && flags.command_data_flag;
    // data bytes are taken whenever the sequencer is idle; commands only when the reply slot is also free
    assign take = (state_reg == ppc_pkg::ST_IDLE) && flags.in_buffer_full_flag
                  && (!flags.command_data_flag || !flags.out_buffer_full_flag);
    assign busy = state_reg != ppc_pkg::ST_IDLE;
    assign place = state_reg == ppc_pkg::ST_REPLY;
    assign place_is_status = op_reg == ppc_pkg::OP_DETAIL;
    assign place_byte = (op_reg == ppc_pkg::OP_DETAIL) ? detail : sample_reg;

    always_ff @(posedge clk) begin
        if (srst) begin
            state_reg <= ppc_pkg::ST_IDLE;
            op_reg <= ppc_pkg::OP_OUT;
        end else begin
            unique case (state_reg)
                ppc_pkg::ST_IDLE: begin
                    if (take && is_cmd && !in_byte[ppc_pkg::CMD_IRQ]) begin
                        op_reg <= in_byte[5:4];
                        unique case (in_byte[5:4])
                            ppc_pkg::OP_OUT: state_reg <= ppc_pkg::ST_PLACE;
                            ppc_pkg::OP_DETAIL: state_reg <= ppc_pkg::ST_REPLY;
                            default: state_reg <= ppc_pkg::ST_SETUP;
                        endcase
                    end
                end
                ppc_pkg::ST_PLACE: state_reg <= ppc_pkg::ST_SETUP;
                ppc_pkg::ST_SETUP: begin
                    if (op_reg == ppc_pkg::OP_READER) begin
                        state_reg <= ppc_pkg::ST_HOLD;
                    end else begin
                        state_reg <= ppc_pkg::ST_ENABLE;
                    end
                end
                ppc_pkg::ST_ENABLE: state_reg <= ppc_pkg::ST_HOLD;
                ppc_pkg::ST_HOLD: begin
                    if (hold_reg == 4'h0) begin
                        if (op_reg == ppc_pkg::OP_READER) begin
                            state_reg <= ppc_pkg::ST_RESTORE;
                        end else begin
                            state_reg <= ppc_pkg::ST_DISABLE;
                        end
                    end
                end
                ppc_pkg::ST_DISABLE: state_reg <= ppc_pkg::ST_RESTORE;
                ppc_pkg::ST_RESTORE: begin
                    if (op_reg == ppc_pkg::OP_OUT) begin
                        state_reg <= ppc_pkg::ST_IDLE;
                    end else begin
                        state_reg <= ppc_pkg::ST_REPLY;
                    end
                end
                ppc_pkg::ST_REPLY: state_reg <= ppc_pkg::ST_IDLE;
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            hold_reg <= 4'h0;
        end else if (state_reg == ppc_pkg::ST_HOLD) begin
            hold_reg <= hold_reg - 4'h1;
        end else begin
            hold_reg <= ppc_pkg::HOLD_LOAD;
        end
    end

    // control port: every change is one whole write, as the decoder expects
    always_ff @(posedge clk) begin
        if (srst) begin
            ctrl_reg <= ppc_pkg::CTRL_RESET;
        end else begin
            unique case (state_reg)
                ppc_pkg::ST_IDLE: begin
                    if (take && is_cmd && in_byte[ppc_pkg::CMD_IRQ]) begin
                        ctrl_reg[ppc_pkg::CTL_IRQ] <= in_byte[0];
                    end
                end
                ppc_pkg::ST_SETUP: begin
                    ctrl_reg[3:0] <= in_byte[3:0];
                    ctrl_reg[ppc_pkg::CTL_ENA_N] <= 1'b1;
                    ctrl_reg[ppc_pkg::CTL_RP_DIR] <= op_reg != ppc_pkg::OP_READER;
                    ctrl_reg[ppc_pkg::CTL_PG_DIR] <= !(op_reg == ppc_pkg::OP_STROBE_IN
                        && (in_byte[3:0] == ppc_pkg::SEL_PG_RD_DATA
                        || in_byte[3:0] == ppc_pkg::SEL_PG_RD_STAT));
                end
                ppc_pkg::ST_ENABLE: ctrl_reg[ppc_pkg::CTL_ENA_N] <= 1'b0;
                ppc_pkg::ST_DISABLE: ctrl_reg[ppc_pkg::CTL_ENA_N] <= 1'b1;
                ppc_pkg::ST_RESTORE: begin
                    ctrl_reg[ppc_pkg::CTL_RP_DIR] <= 1'b1;
                    ctrl_reg[ppc_pkg::CTL_PG_DIR] <= 1'b1;
                end
                default: ctrl_reg <= ctrl_reg;
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            host_irq <= 1'b0;
            reader_punch_dir <= 1'b1;
            programmer_dir <= 1'b1;
        end else begin
            host_irq <= ctrl_reg[ppc_pkg::CTL_IRQ];
            reader_punch_dir <= ctrl_reg[ppc_pkg::CTL_RP_DIR];
            programmer_dir <= ctrl_reg[ppc_pkg::CTL_PG_DIR];
        end
    end

    strobe_decoder decoder (
        .clk(clk),
        .rst(srst),
        .code(ctrl_reg[3:0]),
        .enable_n(ctrl_reg[ppc_pkg::CTL_ENA_N]),
        .strobes(strobes)
    );

    // the printer pair looks inward only while the status strobe is low
    always_ff @(posedge clk) begin
        if (srst) begin
            printer_dir <= 1'b1;
        end else begin
            printer_dir <= !(!ctrl_reg[ppc_pkg::CTL_ENA_N]
                && ctrl_reg[3:0] == ppc_pkg::SEL_STATUS);
        end
    end

    // peripheral data port
    always_ff @(posedge clk) begin
        if (srst) begin
            out_data_reg <= ppc_pkg::DATA_IDLE;
        end else if (take && !flags.command_data_flag) begin
            out_data_reg <= in_byte;
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            periph_data_out <= ppc_pkg::DATA_IDLE;
            periph_data_oe_n <= 1'b1;
        end else if (state_reg == ppc_pkg::ST_PLACE) begin
            periph_data_out <= out_data_reg;
            periph_data_oe_n <= 1'b0;
        end else if (state_reg == ppc_pkg::ST_RESTORE) begin
            periph_data_out <= ppc_pkg::DATA_IDLE;
            periph_data_oe_n <= 1'b1;
        end
    end

    // sample at the end of the strobe, after the input synchroniser settles
    always_ff @(posedge clk) begin
        if (srst) begin
            sample_reg <= 8'h00;
            status_reg <= ppc_pkg::STATUS_RESET;
        end else if (state_reg == ppc_pkg::ST_HOLD && hold_reg == 4'h0) begin
            sample_reg <= pdata_s2_reg;
            if (op_reg == ppc_pkg::OP_STROBE_IN && ctrl_reg[3:0] == ppc_pkg::SEL_STATUS) begin
                status_reg <= pdata_s2_reg | ~ppc_pkg::STATUS_VALID_MASK;
            end
        end
    end

    // short acknowledge pulses are caught on their falling edge
    assign ack_edge = ack_s3_reg && !ack_s2_reg;
    assign ack_clear = place && op_reg == ppc_pkg::OP_DETAIL && in_byte[1:0] == 2'h3;
    always_ff @(posedge clk) begin
        if (srst) begin
            ack_seen_reg <= 1'b0;
        end else if (ack_edge) begin
            ack_seen_reg <= 1'b1;
        end else if (ack_clear) begin
            ack_seen_reg <= 1'b0;
        end
    end

    // detail byte, active high: [0] ready or busy, [1] powered or online, [2] ack
    always_comb begin
        detail = 8'h00;
        unique case (in_byte[1:0])
            2'h0: begin
                detail[0] = !status_reg[ppc_pkg::ST_PUNCH_RDY];
                detail[1] = !status_reg[ppc_pkg::ST_PUNCH_PWR];
            end
            2'h1: begin
                detail[0] = !status_reg[ppc_pkg::ST_READER_RDY];
                detail[1] = !status_reg[ppc_pkg::ST_READER_PWR];
            end
            2'h2: begin
                detail[0] = !status_reg[ppc_pkg::ST_PRN_BUSY];
                detail[1] = !status_reg[ppc_pkg::ST_PRN_ONLINE];
            end
            2'h3: detail[2] = ack_seen_reg;
        endcase
    end
endmodule : parallel_peripheral_port_controller

// ==== test/ppc_props.sv ====
// port assertions for the parallel peripheral port controller
`timescale 1ns/10ps
module ppc_props (
    // clock and resets
    input wire logic clk,
    input wire logic rst,
    input wire logic system_init_n,
    // host side
    input wire logic port_select_n,
    input wire logic host_rd_n,
    input wire logic host_data_oe_n,
    // peripheral side
    input wire logic periph_data_oe_n,
    input wire logic reader_punch_dir,
    input wire logic programmer_dir,
    input wire logic printer_dir,
    input wire ppc_pkg::strobe_type strobes
);
    logic [12:0] sv;
    logic quiet;
    logic rdsel;
    assign sv = strobes;
    assign quiet = &sv;
    assign rdsel = !host_rd_n && !port_select_n;
    default clocking @(posedge clk);
    endclocking
    // init aborts any sequence, so it silences the checks as reset does
    default disable iff (rst || !system_init_n);
    sequence held_low;
        !quiet [*8];
    endsequence
    sequence held_quiet;
        quiet [*8];
    endsequence
    a_reset_idle: assert property ($fell(rst) |-> quiet && periph_data_oe_n && host_data_oe_n
        && {reader_punch_dir, programmer_dir, printer_dir} == 3'h7) else $error("not idle");
    a_one_strobe: assert property ($countones(~sv) <= 1) else $error("two strobes");
    a_read_drive: assert property ($fell(host_data_oe_n) |-> $past(rdsel) && $past(rdsel, 2))
        else $error("drive without read");
    a_strobe_width: assert property ($fell(quiet) |-> held_low) else $error("short strobe");
    a_out_dirs: assert property (!periph_data_oe_n |-> reader_punch_dir && programmer_dir)
        else $error("output with pair inward");
    a_reader_quiet: assert property ($fell(reader_punch_dir) |-> held_quiet)
        else $error("strobe in reader read");
    a_prog_inward: assert property ($fell(programmer_dir) |-> ##[1:4] (!sv[3] || !sv[4]))
        else $error("programmer pair inward without read");
    a_status_inward: assert property ($fell(printer_dir) |-> ##[0:2] !sv[12])
        else $error("printer pair inward without status");
endmodule : ppc_props

// ==== test/periph_model.sv ====
// behavioural tape, printer and programmer side of the peripheral port
`timescale 1ns/10ps
module periph_model (
    // clock and controller outputs
    input wire logic clk,
    input wire logic [7:0] data_out,
    input wire logic data_oe_n,
    input wire logic reader_punch_dir,
    input wire logic programmer_dir,
    input wire logic printer_dir,
    input wire ppc_pkg::strobe_type strobes,
    // bytes on offer
    input wire logic [7:0] status_byte,
    input wire logic [7:0] reader_byte,
    input wire logic [7:0] prog_byte,
    // toward the controller and the bench
    output logic [7:0] data_in,
    output logic ack_n,
    output logic [12:0] last_strobes,
    output logic [7:0] last_byte
);
    logic w0_prev = 1'b1;
    // lines nobody drives show the inverse, so a stale sample cannot match
    assign data_in = !printer_dir ? status_byte
        : !programmer_dir ? prog_byte
        : !reader_punch_dir ? reader_byte : ~data_out;
    // one-cycle acknowledge after each pulse of programmer write strobe 0
    assign ack_n = !(strobes.programmer_write_strobe_0_n && !w0_prev);
    always_ff @(posedge clk) begin
        w0_prev <= strobes.programmer_write_strobe_0_n;
        if (strobes != 13'h1FFF) begin
            last_strobes <= strobes;
            last_byte <= data_oe_n ? 8'h00 : data_out;
        end
    end
endmodule : periph_model

// ==== test/parallel_peripheral_port_controller_test.sv ====
// self-checking bench for the parallel peripheral port controller
`timescale 1ns/10ps
module parallel_peripheral_port_controller_test;
    logic clk = 1'b0, rst = 1'b1, init_n = 1'b1, sel_n = 1'b1, rd_n = 1'b1, wr_n = 1'b1;
    logic a0 = 1'b0, hoe_n, irq, poe_n, rp_dir, pg_dir, pr_dir, ack_n;
    logic [7:0] hdi = 8'h00, stat = 8'hFF, rdr = 8'hFF, prg = 8'hFF, hdo, pdi, pdo, lbyte;
    logic [12:0] lstrb;
    ppc_pkg::strobe_type strobes;
    int err_count = 0, num_checks = 0, cyc = 0;

    parallel_peripheral_port_controller dut (.clk(clk), .rst(rst), .system_init_n(init_n),
        .port_select_n(sel_n), .host_rd_n(rd_n), .host_wr_n(wr_n), .host_addr_lsb(a0),
        .host_data_in(hdi), .host_data_out(hdo), .host_data_oe_n(hoe_n), .host_irq(irq),
        .periph_data_in(pdi), .periph_data_out(pdo), .periph_data_oe_n(poe_n),
        .reader_punch_dir(rp_dir), .programmer_dir(pg_dir), .printer_dir(pr_dir),
        .strobes(strobes), .pulse_sense_input(ack_n));
    periph_model far (.clk(clk), .data_out(pdo), .data_oe_n(poe_n), .reader_punch_dir(rp_dir),
        .programmer_dir(pg_dir), .printer_dir(pr_dir), .strobes(strobes), .status_byte(stat),
        .reader_byte(rdr), .prog_byte(prg), .data_in(pdi), .ack_n(ack_n),
        .last_strobes(lstrb), .last_byte(lbyte));

    initial forever #50 clk = ~clk;
    always @(posedge clk) begin
        cyc++;
        if (cyc == 20000) begin
            err_count++;
            end_sim();
        end
    end

    task automatic end_sim();
        $display("checks %0d mismatches %0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : end_sim

    task automatic chk(input string what, input logic [12:0] seen, input logic [12:0] exp);
        num_checks++;
        if (seen !== exp) begin
            err_count++;
            $display("unexpected %s: expected %h, seen %h", what, exp, seen);
        end
    endtask : chk

    // strobe held 6 cycles, data left in place after release for the sync lag
    task automatic host_io(input logic rd, input logic sel, input logic lsb,
        input logic [7:0] b, output logic [7:0] v);
        @(posedge clk);
        sel_n <= !sel;
        rd_n <= !rd;
        wr_n <= rd;
        a0 <= lsb;
        hdi <= b;
        repeat (6) @(posedge clk);
        v = hdo;
        if (rd)
            chk("host drive", hoe_n, !sel);
        sel_n <= 1'b1;
        rd_n <= 1'b1;
        wr_n <= 1'b1;
        repeat (6) @(posedge clk);
    endtask : host_io

    task automatic poll(input logic [7:0] mask, input logic [7:0] want);
        logic [7:0] f;
        int n;
        n = 0;
        f = ~want;
        while ((f & mask) !== want && n < 60) begin
            host_io(1'b1, 1'b1, 1'b1, 8'h00, f);
            n++;
        end
        chk("flags", f & mask, want);
    endtask : poll

    task automatic wr(input logic lsb, input logic [7:0] b);
        logic [7:0] v;
        host_io(1'b0, 1'b1, lsb, b, v);
        poll(8'h02, 8'h00);
    endtask : wr

    task automatic ask(input logic [7:0] cmd, input logic cd, input logic [7:0] m,
        input logic [7:0] want);
        logic [7:0] v;
        wr(1'b1, cmd);
        poll(8'h01, 8'h01);
        host_io(1'b1, 1'b1, 1'b1, 8'h00, v);
        chk("reply kind", v[3], cd);
        host_io(1'b1, 1'b1, 1'b0, 8'h00, v);
        chk("reply", v & m, want);
    endtask : ask

    task automatic idle(input string tname);
        chk("strobes", strobes, 13'h1FFF);
        chk("data port", {poe_n, pdo}, 9'h1FF);
        chk("dirs", {rp_dir, pg_dir, pr_dir}, 3'h7);
        $display("%s test done", tname);
    endtask : idle

    task automatic t_host();
        logic [7:0] v;
        host_io(1'b0, 1'b0, 1'b1, 8'h81, v);
        host_io(1'b1, 1'b0, 1'b1, 8'h00, v);
        poll(8'h0F, 8'h00);
        wr(1'b1, 8'h81);
        chk("irq", irq, 1'b1);
        wr(1'b1, 8'h80);
        chk("irq", irq, 1'b0);
        $display("host test done");
    endtask : t_host

    task automatic t_outputs();
        for (int c = 0; c < 16; c++) begin
            wr(1'b0, {4'hA, 4'(c)});
            wr(1'b1, {4'h0, 4'(c)});
            poll(8'h06, 8'h00);
            chk("strobe", lstrb, ~(13'h1 << (c < 13 ? c : 12)));
            chk("byte", lbyte, {4'hA, 4'(c < 13 ? c : 12)});
        end
        idle("output");
    endtask : t_outputs

    task automatic t_inputs();
        @(posedge clk);
        stat <= 8'hA5;
        rdr <= 8'hC3;
        prg <= 8'h3C;
        ask(8'h1C, 1'b0, 8'hFF, 8'hA5);
        ask(8'h30, 1'b1, 8'hFF, 8'h02);
        ask(8'h31, 1'b1, 8'hFF, 8'h02);
        ask(8'h32, 1'b1, 8'hFF, 8'h03);
        ask(8'h13, 1'b0, 8'hFF, 8'h3C);
        ask(8'h14, 1'b0, 8'hFF, 8'h3C);
        ask(8'h20, 1'b0, 8'hFF, 8'hC3);
        wr(1'b0, 8'h11);
        wr(1'b1, 8'h00);
        poll(8'h06, 8'h00);
        ask(8'h33, 1'b1, 8'h04, 8'h04);
        ask(8'h33, 1'b1, 8'h04, 8'h00);
        idle("input");
    endtask : t_inputs

    task automatic t_init();
        logic [7:0] v;
        wr(1'b0, 8'h5A);
        // no flag poll, so init lands while the printer strobe is still low
        host_io(1'b0, 1'b1, 1'b1, 8'h09, v);
        init_n <= 1'b0;
        repeat (4) @(posedge clk);
        chk("abort", strobes, 13'h1FFF);
        init_n <= 1'b1;
        repeat (4) @(posedge clk);
        poll(8'h07, 8'h00);
        idle("init");
    endtask : t_init

    initial begin
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        repeat (2) @(posedge clk);
        idle("reset");
        t_host();
        t_outputs();
        t_inputs();
        t_init();
        end_sim();
    end
endmodule : parallel_peripheral_port_controller_test

bind parallel_peripheral_port_controller ppc_props props (.clk(clk), .rst(rst),
    .system_init_n(system_init_n), .port_select_n(port_select_n), .host_rd_n(host_rd_n),
    .host_data_oe_n(host_data_oe_n), .periph_data_oe_n(periph_data_oe_n),
    .reader_punch_dir(reader_punch_dir), .programmer_dir(programmer_dir),
    .printer_dir(printer_dir), .strobes(strobes));
